// File: shared/tic_pkg.sv
// Purpose: Shared constants of the trigger integration and claim register group
// Assumes: APB with 32-bit data, 12-bit byte address
// Notes: Offsets are byte addresses of aligned words

package tic_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int TIC_ADDR_W = 12;
    localparam int TIC_DATA_W = 32;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [11:0] TIC_OFF_CHAN_OUT_ACK = 12'h000;
    localparam logic [11:0] TIC_OFF_TRIG_OUT_ACK = 12'h004;
    localparam logic [11:0] TIC_OFF_CHAN_IN = 12'h008;
    localparam logic [11:0] TIC_OFF_TRIG_IN = 12'h00C;
    localparam logic [11:0] TIC_OFF_TEST_MODE = 12'h010;
    localparam logic [11:0] TIC_OFF_TAG_SET = 12'h014;
    localparam logic [11:0] TIC_OFF_TAG_CLEAR = 12'h018;
    localparam logic [11:0] TIC_OFF_MAIN_CTRL = 12'h01C;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int TIC_TEST_MODE_BIT = 0;
    localparam int TIC_MAIN_EN_BIT = 0;
    localparam logic TIC_TEST_MODE_RST = 1'b0;
    localparam logic TIC_MAIN_EN_RST = 1'b0;
    localparam logic [31:0] TIC_RDATA_RST = 32'h0000_0000;

    // ****************************************************************
    // Documented line counts
    // ****************************************************************
    localparam int TIC_CHAN_N = 4;
    localparam int TIC_TRIG_N = 8;
    localparam int TIC_TAG_N = 4;

    // ****************************************************************
    // Bus slave states
    // ****************************************************************
    typedef enum logic [0:0] {
        TIC_ST_IDLE = 1'b0,
        TIC_ST_ACCESS = 1'b1
    } tic_state_e;

endpackage : tic_pkg

// File: core/tic_sync.sv
// Purpose: Two-flop synchroniser for a group of external levels
// Assumes: Inputs are asynchronous to pclk
// Notes: Only the second stage is visible outside

`timescale 1ns/1ps

module tic_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // ****************************************************************
    // Synchroniser stages
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;

endmodule : tic_sync

// File: core/tic_regs.sv
// Purpose: Integration read-back, mode control and claim tag registers
// Assumes: APB slave on pclk, asynchronous active-low presetn
// Notes: Output-driving test registers and the trigger matrix are outside
//
// Summary of operation
// - Read channel-output acknowledge lines in bits 3:0
// - Read trigger-output acknowledge lines in bits 7:0
// - Read incoming channel lines in bits 3:0
// - Read incoming trigger lines in bits 7:0
// - Mode bit 0: 0 functional, 1 integration
// - Integration mode hands pins to test registers
// - Normal function not guaranteed in integration mode
// - Claim tag is storage only, no effect
// - Tag-set read returns implemented-bit mask
// - Tag-set write ones set tag bits
// - Tag-clear register drives tag bits to zero
// - Tag-clear read returns current tag value
// - Tag-clear write ones clear tag bits
//
// Implementation choices: register access over APB and the register addresses.

`timescale 1ns/1ps

module tic_regs
    import tic_pkg::*;
#(
    parameter int CHAN_N = tic_pkg::TIC_CHAN_N,
    parameter int TRIG_N = tic_pkg::TIC_TRIG_N,
    parameter int TAG_N = tic_pkg::TIC_TAG_N
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tic_pkg::TIC_ADDR_W-1:0] paddr,
    input wire logic [tic_pkg::TIC_DATA_W-1:0] pwdata,
    output logic [tic_pkg::TIC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Lines from the channel matrix and local trigger logic
    input wire logic [CHAN_N-1:0] chan_in,
    input wire logic [TRIG_N-1:0] trig_in,
    input wire logic [CHAN_N-1:0] chan_out_ack,
    input wire logic [TRIG_N-1:0] trig_out_ack,
    // Mode outputs
    output logic test_mode_enable,
    output logic unit_enable,
    output logic test_active
);

    import tic_pkg::*;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    if (CHAN_N < 1 || CHAN_N > TIC_DATA_W) begin : g_chan_chk
        $error("CHAN_N out of range");
    end
    if (TRIG_N < 1 || TRIG_N > TIC_DATA_W) begin : g_trig_chk
        $error("TRIG_N out of range");
    end
    if (TAG_N < 1 || TAG_N > TIC_DATA_W) begin : g_tag_chk
        $error("TAG_N out of range");
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [CHAN_N-1:0] chan_in_s;
    logic [TRIG_N-1:0] trig_in_s;
    logic [CHAN_N-1:0] chan_ack_s;
    logic [TRIG_N-1:0] trig_ack_s;

    tic_sync #(.WIDTH(CHAN_N)) u_sync_chan_in (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(chan_in),
        .sync_out(chan_in_s)
    );

    tic_sync #(.WIDTH(TRIG_N)) u_sync_trig_in (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(trig_in),
        .sync_out(trig_in_s)
    );

    tic_sync #(.WIDTH(CHAN_N)) u_sync_chan_ack (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(chan_out_ack),
        .sync_out(chan_ack_s)
    );

    tic_sync #(.WIDTH(TRIG_N)) u_sync_trig_ack (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(trig_out_ack),
        .sync_out(trig_ack_s)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    tic_state_e state_ff, nxt_state;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [TIC_DATA_W-1:0] prdata_ff, nxt_prdata;
    logic mode_ff, nxt_mode;
    logic main_en_ff, nxt_main_en;
    logic active_ff, nxt_active;
    logic [TAG_N-1:0] tag_ff, nxt_tag;

    logic setup;
    logic accept;
    logic hit;
    logic [TIC_DATA_W-1:0] rd_word;
    logic [TIC_DATA_W-1:0] tag_mask_word;

    assign setup = psel && !penable;
    assign accept = psel && penable && pready_ff;
    assign tag_mask_word = TIC_DATA_W'({TAG_N{1'b1}});

    // ****************************************************************
    // Address decode and read mux
    // ****************************************************************
    always_comb begin
        hit = 1'b1;
        rd_word = '0;
        case (paddr)
            TIC_OFF_CHAN_OUT_ACK: rd_word = TIC_DATA_W'(chan_ack_s);
            TIC_OFF_TRIG_OUT_ACK: rd_word = TIC_DATA_W'(trig_ack_s);
            TIC_OFF_CHAN_IN: rd_word = TIC_DATA_W'(chan_in_s);
            TIC_OFF_TRIG_IN: rd_word = TIC_DATA_W'(trig_in_s);
            TIC_OFF_TEST_MODE: rd_word = TIC_DATA_W'(mode_ff);
            TIC_OFF_TAG_SET: rd_word = tag_mask_word;
            TIC_OFF_TAG_CLEAR: rd_word = TIC_DATA_W'(tag_ff);
            TIC_OFF_MAIN_CTRL: rd_word = TIC_DATA_W'(main_en_ff);
            default: hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        case (state_ff)
            TIC_ST_IDLE: begin
                if (setup) begin
                    nxt_state = TIC_ST_ACCESS;
                    nxt_pready = 1'b1;
                    nxt_pslverr = !hit;
                    nxt_prdata = (!pwrite && hit) ? rd_word : '0;
                end
            end
            TIC_ST_ACCESS: begin
                if (accept || !psel) begin
                    nxt_state = TIC_ST_IDLE;
                end else begin
                    nxt_pready = pready_ff;
                    nxt_pslverr = pslverr_ff;
                end
            end
            default: nxt_state = TIC_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= TIC_ST_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= TIC_RDATA_RST;
        end else begin
            state_ff <= nxt_state;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // ****************************************************************
    // Writable registers
    // ****************************************************************
    always_comb begin
        nxt_mode = mode_ff;
        nxt_main_en = main_en_ff;
        nxt_tag = tag_ff;
        if (accept && pwrite) begin
            case (paddr)
                TIC_OFF_TEST_MODE: nxt_mode = pwdata[TIC_TEST_MODE_BIT];
                TIC_OFF_MAIN_CTRL: nxt_main_en = pwdata[TIC_MAIN_EN_BIT];
                TIC_OFF_TAG_SET: nxt_tag = tag_ff | pwdata[TAG_N-1:0];
                TIC_OFF_TAG_CLEAR: nxt_tag = tag_ff & ~pwdata[TAG_N-1:0];
                default: nxt_tag = tag_ff;
            endcase
        end
        nxt_active = nxt_mode && nxt_main_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= TIC_TEST_MODE_RST;
            main_en_ff <= TIC_MAIN_EN_RST;
            active_ff <= 1'b0;
            tag_ff <= '0;
        end else begin
            mode_ff <= nxt_mode;
            main_en_ff <= nxt_main_en;
            active_ff <= nxt_active;
            tag_ff <= nxt_tag;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign test_mode_enable = mode_ff;
    assign unit_enable = main_en_ff;
    assign test_active = active_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_after_setup_a: assert property ( // bus
        (state_ff == TIC_ST_IDLE && setup) |=> pready_ff)
        else $error("pready missing after setup");

    chan_ack_read_a: assert property (
        (state_ff == TIC_ST_IDLE && setup && !pwrite && paddr == TIC_OFF_CHAN_OUT_ACK)
        |=> prdata_ff == TIC_DATA_W'($past(chan_ack_s)))
        else $error("channel ack read-back wrong");

    trig_ack_read_a: assert property (
        (state_ff == TIC_ST_IDLE && setup && !pwrite && paddr == TIC_OFF_TRIG_OUT_ACK)
        |=> prdata_ff == TIC_DATA_W'($past(trig_ack_s)))
        else $error("trigger ack read-back wrong");

    chan_in_read_a: assert property (
        (state_ff == TIC_ST_IDLE && setup && !pwrite && paddr == TIC_OFF_CHAN_IN)
        |=> prdata_ff == TIC_DATA_W'($past(chan_in_s)))
        else $error("channel input read-back wrong");

    trig_in_read_a: assert property (
        (state_ff == TIC_ST_IDLE && setup && !pwrite && paddr == TIC_OFF_TRIG_IN)
        |=> prdata_ff[TIC_DATA_W-1:TRIG_N] == '0 && prdata_ff[TRIG_N-1:0] == $past(trig_in_s))
        else $error("trigger input read-back wrong");

    mode_write_a: assert property (
        (accept && pwrite && paddr == TIC_OFF_TEST_MODE)
        |=> test_mode_enable == $past(pwdata[TIC_TEST_MODE_BIT]))
        else $error("mode bit not written");

    active_gate_a: assert property (
        ##1 test_active == (test_mode_enable && unit_enable))
        else $error("integration active mismatch");

    tag_mask_read_a: assert property (
        (state_ff == TIC_ST_IDLE && setup && !pwrite && paddr == TIC_OFF_TAG_SET)
        |=> prdata_ff == tag_mask_word)
        else $error("tag mask read wrong");

    tag_set_a: assert property (
        (accept && pwrite && paddr == TIC_OFF_TAG_SET)
        |=> tag_ff == ($past(tag_ff) | $past(pwdata[TAG_N-1:0])))
        else $error("tag set wrong");

    tag_clear_a: assert property (
        (accept && pwrite && paddr == TIC_OFF_TAG_CLEAR)
        |=> tag_ff == ($past(tag_ff) & ~$past(pwdata[TAG_N-1:0])))
        else $error("tag clear wrong");

    tag_value_read_a: assert property (
        (state_ff == TIC_ST_IDLE && setup && !pwrite && paddr == TIC_OFF_TAG_CLEAR)
        |=> prdata_ff == TIC_DATA_W'($past(tag_ff)))
        else $error("tag value read wrong");

    tag_isolated_a: assert property (
        (tag_ff != $past(tag_ff)) |-> $stable(test_active) && $stable(test_mode_enable))
        else $error("tag change disturbed mode");

    readonly_write_a: assert property (
        (accept && pwrite && paddr <= TIC_OFF_TRIG_IN)
        |=> $stable(tag_ff) && $stable(mode_ff) && $stable(main_en_ff))
        else $error("read-only write changed state");

    tag_set_c: cover property (accept && pwrite && paddr == TIC_OFF_TAG_SET);
    tag_clear_c: cover property (accept && pwrite && paddr == TIC_OFF_TAG_CLEAR);
    active_c: cover property (!test_active ##1 test_active);
    unmapped_c: cover property (accept && pslverr_ff);

endmodule : tic_regs

// File: tb/tic_far_model.sv
// Purpose: Far-side model of channel matrix and local trigger lines
// Assumes: Bench gives the wanted levels as one packed word
// Notes: Slow mode adds one extra cycle before the lines move

`timescale 1ns/1ps

module tic_far_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Commands from bench
    input wire logic slow,
    input wire logic [23:0] want,
    // Lines to the unit
    output logic [3:0] chan_in,
    output logic [7:0] trig_in,
    output logic [3:0] chan_out_ack,
    output logic [7:0] trig_out_ack
);
    // ****************************************************************
    // Line drivers
    // ****************************************************************
    logic [23:0] stage_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_ff <= 24'h000000;
            {chan_in, trig_in, chan_out_ack, trig_out_ack} <= 24'h000000;
        end else begin
            stage_ff <= want;
            {chan_in, trig_in, chan_out_ack, trig_out_ack} <= slow ? stage_ff : want;
        end
    end
endmodule : tic_far_model

// File: tb/tb_top.sv
// Purpose: Self-checking bench of the integration and claim register group
// Assumes: APB master on pclk, zero-wait slave, far-side model on the lines
// Notes: Lines are given six cycles to pass the synchronisers

`timescale 1ns/1ps

module tb_top;
    import tic_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] want;
    logic [3:0] chan_in, chan_out_ack;
    logic [7:0] trig_in, trig_out_ack;
    logic test_mode_enable, unit_enable, test_active;
    int miscompares, checks_done, cycles;

    tic_regs #(.CHAN_N(4), .TRIG_N(8), .TAG_N(4)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_in(chan_in), .trig_in(trig_in),
        .chan_out_ack(chan_out_ack), .trig_out_ack(trig_out_ack),
        .test_mode_enable(test_mode_enable), .unit_enable(unit_enable),
        .test_active(test_active)
    );

    tic_far_model i_far (
        .pclk(pclk), .presetn(presetn), .slow(slow), .want(want),
        .chan_in(chan_in), .trig_in(trig_in),
        .chan_out_ack(chan_out_ack), .trig_out_ack(trig_out_ack)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task end_of_test;
        $display("comparisons %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(exp, rd);
        chk(32'h0000_0000, {31'h0, err});
    endtask : rdchk

    task outs(input logic [2:0] exp);
        @(negedge pclk);
        chk({29'h0, exp}, {29'h0, test_mode_enable, unit_enable, test_active});
    endtask : outs

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        outs(3'h0);
        rdchk(TIC_OFF_TAG_SET, 32'h0000_000F);
        rdchk(TIC_OFF_TAG_CLEAR, 32'h0000_0000);
        $display("reset values done");
    endtask : t_reset

    task t_lines(input logic [23:0] p, input logic s, input logic [2:0] o);
        @(posedge pclk);
        slow <= s;
        want <= p;
        repeat (6) @(posedge pclk);
        rdchk(TIC_OFF_CHAN_OUT_ACK, {28'h0, p[11:8]});
        rdchk(TIC_OFF_TRIG_OUT_ACK, {24'h0, p[7:0]});
        rdchk(TIC_OFF_CHAN_IN, {28'h0, p[23:20]});
        rdchk(TIC_OFF_TRIG_IN, {24'h0, p[19:12]});
        for (int i = 0; i < 4; i++) apb(1'b1, 12'(4 * i), 32'hFFFF_FFFF);
        rdchk(TIC_OFF_CHAN_IN, {28'h0, p[23:20]});
        rdchk(TIC_OFF_TRIG_OUT_ACK, {24'h0, p[7:0]});
        outs(o);
        $display("line read-back done");
    endtask : t_lines

    task t_mode;
        apb(1'b1, TIC_OFF_TEST_MODE, 32'hFFFF_FFFF);
        rdchk(TIC_OFF_TEST_MODE, 32'h0000_0001);
        outs(3'h4);
        apb(1'b1, TIC_OFF_MAIN_CTRL, 32'h0000_0001);
        outs(3'h7);
        rdchk(TIC_OFF_MAIN_CTRL, 32'h0000_0001);
        t_lines(24'h3C_96_A5, 1'b1, 3'h7);
        apb(1'b1, TIC_OFF_TEST_MODE, 32'h0000_0000);
        outs(3'h2);
        $display("mode control done");
    endtask : t_mode

    task t_claim;
        apb(1'b1, TIC_OFF_TAG_SET, 32'h0000_0005);
        rdchk(TIC_OFF_TAG_CLEAR, 32'h0000_0005);
        apb(1'b1, TIC_OFF_TAG_SET, 32'hFFFF_FFF0);
        rdchk(TIC_OFF_TAG_CLEAR, 32'h0000_0005);
        apb(1'b1, TIC_OFF_TAG_SET, 32'h0000_000A);
        rdchk(TIC_OFF_TAG_SET, 32'h0000_000F);
        apb(1'b1, TIC_OFF_TAG_CLEAR, 32'h0000_0003);
        rdchk(TIC_OFF_TAG_CLEAR, 32'h0000_000C);
        apb(1'b1, TIC_OFF_TAG_CLEAR, 32'hFFFF_FFF0);
        rdchk(TIC_OFF_TAG_CLEAR, 32'h0000_000C);
        outs(3'h2);
        rdchk(TIC_OFF_TEST_MODE, 32'h0000_0000);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        chk(32'h0000_0001, {31'h0, err});
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(32'h0000_0001, {31'h0, err});
        chk(32'h0000_0000, rd);
        rdchk(TIC_OFF_TAG_CLEAR, 32'h0000_000C);
        $display("claim tag and unmapped done");
    endtask : t_claim

    task t_rst;
        apb(1'b1, TIC_OFF_TEST_MODE, 32'h0000_0001);
        outs(3'h7);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        outs(3'h0);
        rdchk(TIC_OFF_TAG_CLEAR, 32'h0000_0000);
        $display("mid-run reset done");
    endtask : t_rst

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        want = 24'h000000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_lines(24'h5A_5A_5A, 1'b0, 3'h0);
        t_lines(24'hA5_A5_A5, 1'b1, 3'h0);
        t_lines(24'hFF_FF_FF, 1'b0, 3'h0);
        t_mode();
        t_claim();
        t_rst();
        end_of_test();
    end
endmodule : tb_top
